/* rtl/dbgmux_consts.vh */
// Constants for the debug signal bank multiplexer.
// Included by the mux module; definitions only.
`ifndef DBGMUX_CONSTS_VH
`define DBGMUX_CONSTS_VH
// Default pin count and bank count
`define DBGMUX_PIN_COUNT 8
`define DBGMUX_BANK_COUNT 2
// Largest legal pin and bank count
`define DBGMUX_MAX_COUNT 255
// Output mode codes
`define DBGMUX_MODE_TIMING 1'h0
`define DBGMUX_MODE_STATE 1'h1
// Power-up state codes
`define DBGMUX_PWR_TRISTATE 1'h0
`define DBGMUX_PWR_BANK 1'h1
// Default power-up bank
`define DBGMUX_PWR_BANK_SEL 8'h00
// Width of a bank selection
`define DBGMUX_SEL_W 8
`endif

/* rtl/dbgmux_top.v */
// Debug signal bank multiplexer: routes one bank of internal signals
// onto the dedicated debug pins watched by an external logic analyzer.
// Assumes the host selection arrives already on clk (from the JTAG hub)
// and the board header resolves pin levels from the output enables.
// How it works
// - Pin count is a parameter, one to 255.
// - Each pin picks among one to 255 banks.
// - Timing mode passes bank straight, unregistered.
// - State mode registers bank on sample clock.
// - Sample clock is any design signal, build-chosen.
// - Sample clock used only in state mode.
// - Power-up tristates pins or drives chosen bank.
// - Host changes active bank for all pins.
`timescale 1ns/1ns
`include "dbgmux_consts.vh"
module dbgmux_top #(
    parameter PIN_COUNT = `DBGMUX_PIN_COUNT,
    parameter BANK_COUNT = `DBGMUX_BANK_COUNT,
    parameter OUT_MODE = `DBGMUX_MODE_TIMING,
    parameter PWR_STATE = `DBGMUX_PWR_TRISTATE,
    parameter [`DBGMUX_SEL_W-1:0] PWR_BANK = `DBGMUX_PWR_BANK_SEL
)(
    // Clock and reset
    input wire clk,
    input wire rst_b,
    // Sample clock for state mode
    input wire sample_clk,
    // Internal signal banks, bank b at [b*PIN_COUNT +: PIN_COUNT]
    input wire [PIN_COUNT*BANK_COUNT-1:0] bank_data,
    // Host bank selection
    input wire sel_write,
    input wire sel_valid,
    input wire [`DBGMUX_SEL_W-1:0] sel_bank,
    // Debug pins
    output wire [PIN_COUNT-1:0] pin_out,
    output wire [PIN_COUNT-1:0] pin_oe,
    // Current selection status
    output reg active_valid,
    output reg [`DBGMUX_SEL_W-1:0] active_bank
);
    // Pin word with every line low, shown while nothing drives
    localparam [PIN_COUNT-1:0] PINS_LOW = {PIN_COUNT{1'h0}};
    // Selection flag that the reset branch loads
    localparam RST_VALID = (PWR_STATE == `DBGMUX_PWR_BANK);

    // Pick one bank's word out of the flat bank bus
    // Out-of-range selections give all zeros
    function [PIN_COUNT-1:0] pick_bank;
        input [PIN_COUNT*BANK_COUNT-1:0] data;
        input [`DBGMUX_SEL_W-1:0] sel;
        integer b;
        begin
            // Default when no bank matches
            pick_bank = PINS_LOW;
            // Walk every bank and keep the one that matches
            for (b = 0; b < BANK_COUNT; b = b + 1)
            begin
                if (sel == b[`DBGMUX_SEL_W-1:0])
                begin
                    // Bank b occupies its own slice of the bus
                    pick_bank = data[b*PIN_COUNT +: PIN_COUNT];
                end
            end
        end
    endfunction

    // True when a selection names a bank that exists
    function bank_exists;
        input [`DBGMUX_SEL_W-1:0] sel;
        begin
            // Indices from the bank count upward are refused
            bank_exists = (sel < BANK_COUNT);
        end
    endfunction

    // Copy one enable bit onto every pin
    function [PIN_COUNT-1:0] spread;
        input en;
        begin
            // All pins share one enable, never a partial set
            spread = {PIN_COUNT{en}};
        end
    endfunction

    // Force a pin word low unless its enable is set
    function [PIN_COUNT-1:0] gate_word;
        input en;
        input [PIN_COUNT-1:0] word;
        begin
            // Undriven pins read as zero on the value lines
            if (en)
            begin
                gate_word = word;
            end
            else
            begin
                gate_word = PINS_LOW;
            end
        end
    endfunction

    // Selection as seen by the mux; out of range counts as none
    wire sel_ok;
    // Word of the selected bank, before any gating
    wire [PIN_COUNT-1:0] muxed;
    // Next contents of the selection register
    reg next_valid;
    reg [`DBGMUX_SEL_W-1:0] next_bank;

    // Connected only for a valid selection of an existing bank
    assign sel_ok = active_valid && bank_exists(active_bank);
    // Same bank index serves every pin
    assign muxed = pick_bank(bank_data, active_bank);

    // Next selection: a host write replaces both fields together
    always @*
    begin
        // Hold the present selection by default
        next_valid = active_valid;
        next_bank = active_bank;
        if (sel_write)
        begin
            // New selection applies to every pin at once
            next_valid = sel_valid;
            next_bank = sel_bank;
        end
    end

    // Host selection register; reset gives the power-up choice
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            // Tristated or one chosen bank, fixed at build time
            active_valid <= RST_VALID;
            active_bank <= PWR_BANK;
        end
        else
        begin
            // Load whatever the next-state logic decided
            active_valid <= next_valid;
            active_bank <= next_bank;
        end
    end

    // Output stage: one of the two modes is built
    generate
        if (OUT_MODE == `DBGMUX_MODE_STATE)
        begin : g_state
            // Three stages carry the enable into the sample domain
            reg [2:0] en_sync;
            // Bank word captured on the sample clock
            reg [PIN_COUNT-1:0] data_q;
            // Settled enable for the pins
            reg en_q;
            // Next enable, taken once the last two stages agree
            reg next_en;

            // Shift the clk-domain enable through the stages
            always @(posedge sample_clk or negedge rst_b)
            begin
                if (!rst_b)
                begin
                    // Pins stay released until the enable crosses
                    en_sync <= 3'h0;
                end
                else
                begin
                    // Newest sample enters at the bottom
                    en_sync <= {en_sync[1:0], sel_ok};
                end
            end

            // Enable changes only when stages two and three agree
            always @*
            begin
                // Keep the old enable while the stages disagree
                next_en = en_q;
                if (en_sync[1] == en_sync[2])
                begin
                    // Both stages settled on one level
                    next_en = en_sync[2];
                end
            end

            // Sample the chosen bank on the sample clock
            always @(posedge sample_clk or negedge rst_b)
            begin
                if (!rst_b)
                begin
                    // Nothing captured yet
                    data_q <= PINS_LOW;
                    en_q <= 1'h0;
                end
                else
                begin
                    // Debug view: a bank change may show a mixed word
                    data_q <= muxed;
                    en_q <= next_en;
                end
            end

            // Pins follow the registered word and enable
            assign pin_out = gate_word(en_q, data_q);
            assign pin_oe = spread(en_q);
        end
        else
        begin : g_timing
            // No sample clock: bank flows straight to the pins
            // The analyzer's own clock decides when values are seen
            // A bank change shows as soon as the selection loads
            assign pin_out = gate_word(sel_ok, muxed);
            assign pin_oe = spread(sel_ok);
        end
    endgenerate
endmodule // dbgmux_top

/* verification/dbgmux_asserts.sv */
// Pin checker for the bank mux; pin timing checks in timing mode only.
// Bound to dbgmux_top by the testbench.
`timescale 1ns/1ns
module dbgmux_asserts #(parameter PIN_COUNT = 8, parameter BANK_COUNT = 2,
    parameter OUT_MODE = 0, parameter PWR_STATE = 0)(
    // Clock, reset, host and banks
    input wire clk, input wire rst_b, input wire sel_write,
    input wire sel_valid, input wire [7:0] sel_bank,
    input wire [PIN_COUNT*BANK_COUNT-1:0] bank_data,
    // Pins and status
    input wire [PIN_COUNT-1:0] pin_out, input wire [PIN_COUNT-1:0] pin_oe,
    input wire active_valid, input wire [7:0] active_bank
);
default clocking @(posedge clk); endclocking
default disable iff (!rst_b);
// A legal bank is connected
wire on = active_valid && active_bank < BANK_COUNT;
chk_pwr_sel: assert property ($rose(rst_b) |->
    active_valid == (PWR_STATE == 1))
    else $error("wrong power-up selection");
chk_oe_same: assert property (pin_oe == 0 || &pin_oe)
    else $error("pin enables differ");
chk_off_low: assert property (pin_oe == 0 |-> pin_out == 0)
    else $error("released pins not low");
chk_sel_load: assert property (
    sel_write && sel_valid |=> active_bank == $past(sel_bank))
    else $error("bank not loaded");
chk_sel_hold: assert property (
    !sel_write |=> $stable(active_bank) && $stable(active_valid))
    else $error("selection moved");
chk_pins_off: assert property (OUT_MODE == 0 && !on |-> pin_oe == 0)
    else $error("pins driven with no bank");
chk_pins_on: assert property (OUT_MODE == 0 && on |-> &pin_oe &&
    pin_out == PIN_COUNT'(bank_data >> active_bank * PIN_COUNT))
    else $error("pins not the bank");
endmodule // dbgmux_asserts

/* verification/dbgmux_la_model.sv */
// Analyzer on the debug header, own sample clock.
// Undriven lines have no pull, so they show a toggling pattern.
`timescale 1ns/1ns
module dbgmux_la_model (
    // Sample clock and pins
    input wire clk, input wire [7:0] pin_out, input wire [7:0] pin_oe,
    // Captured levels
    output logic [7:0] seen = 8'h00
);
// Sample driven lines, flip the released ones
always @(posedge clk) seen <= pin_out & pin_oe | ~seen & ~pin_oe;
endmodule // dbgmux_la_model

/* verification/dbgmux_tb.sv */
// Bench for the bank mux in timing mode plus a state-mode copy, defaults 8 pins 2 banks.
// Host picks banks; pins and analyzer view are judged.
`timescale 1ns/1ns
module testbench;
logic clk = 0, la_clk = 0, rst_b = 0, sel_write = 0, sel_valid = 0;
logic [7:0] sel_bank = 8'h00;
logic [15:0] bank_data = 16'hA55A;
wire [7:0] pin_out, pin_oe, seen, active_bank;
wire active_valid;
wire [7:0] st_out, st_oe, st_bank;
wire st_valid;
int mismatches = 0, checks = 0;
always #2 clk = ~clk;
always #3 la_clk = ~la_clk;
dbgmux_top u_dbgmux_top (.clk(clk), .rst_b(rst_b), .sample_clk(1'b0),
    .bank_data(bank_data), .sel_write(sel_write), .sel_valid(sel_valid),
    .sel_bank(sel_bank), .pin_out(pin_out), .pin_oe(pin_oe),
    .active_valid(active_valid), .active_bank(active_bank));
// State mode, power-up on bank 1, sampled on the analyzer clock
dbgmux_top #(.OUT_MODE(1'h1), .PWR_STATE(1'h1), .PWR_BANK(8'h01))
    u_dbgmux_top_state (.clk(clk), .rst_b(rst_b), .sample_clk(la_clk),
    .bank_data(bank_data), .sel_write(sel_write), .sel_valid(sel_valid),
    .sel_bank(sel_bank), .pin_out(st_out), .pin_oe(st_oe),
    .active_valid(st_valid), .active_bank(st_bank));
dbgmux_la_model u_dbgmux_la_model (.clk(la_clk), .pin_out(pin_out),
    .pin_oe(pin_oe), .seen(seen));
// Compare one pin word
task automatic cmp(input string n, input logic [7:0] e, g);
    checks++;
    if (g !== e)
    begin
        mismatches++;
        $display("BAD %s expected %h seen %h", n, e, g);
    end
endtask
// One-cycle host selection, then let it land
task automatic pick(input logic v, input logic [7:0] b);
    @(posedge clk) {sel_write, sel_valid, sel_bank} <= {1'b1, v, b};
    @(posedge clk) sel_write <= 1'b0;
    #1;
endtask
// State-mode copy drives its power-up bank once enables cross
task automatic t_state;
    repeat (6) @(negedge la_clk);
    cmp("state oe", 8'hFF, st_oe);
    cmp("state pins", 8'hA5, st_out);
    cmp("state bank", 8'h01, st_bank);
    cmp("state valid", 8'h01, {7'h00, st_valid});
    $display("t_state done");
endtask
// Banks back to back, then a live data change
task automatic t_banks;
    cmp("off at start", 8'h00, pin_oe);
    pick(1'b1, 8'h00);
    cmp("bank0", 8'h5A, pin_out);
    pick(1'b1, 8'h01);
    cmp("oe", 8'hFF, pin_oe);
    @(posedge clk) bank_data <= 16'h3C5A;
    #1 cmp("live", 8'h3C, pin_out);
    repeat (2) @(negedge la_clk);
    cmp("analyzer", 8'h3C, seen);
    $display("t_banks done");
endtask
// Refused bank and explicit release
task automatic t_off;
    pick(1'b1, 8'h02);
    cmp("refused", 8'h00, pin_oe);
    pick(1'b0, 8'h01);
    cmp("off", 8'h00, pin_oe | pin_out);
    repeat (6) @(negedge la_clk);
    cmp("state off", 8'h00, st_oe | st_out);
    $display("t_off done");
endtask
// Verdict and end of run
task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
        $display("All checks passed");
    else
        $display("Checks failed");
    $finish;
endtask
// Reset, then the tests
initial
begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    #1 t_state;
    t_banks;
    t_off;
    complete_run;
end
// Watchdog
initial
begin
    #1000 mismatches++;
    complete_run;
end
endmodule // testbench
bind dbgmux_top dbgmux_asserts #(.PIN_COUNT(PIN_COUNT),
    .BANK_COUNT(BANK_COUNT), .OUT_MODE(OUT_MODE), .PWR_STATE(PWR_STATE))
    u_dbgmux_asserts (.clk(clk), .rst_b(rst_b),
    .sel_write(sel_write), .sel_valid(sel_valid), .sel_bank(sel_bank),
    .bank_data(bank_data), .pin_out(pin_out), .pin_oe(pin_oe),
    .active_valid(active_valid), .active_bank(active_bank));
